/* hbridge_current_chopper.sv */
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "hbridge_regs.svh"
// How it works
// RULE1: trip forces both high sides for off-time
// RULE2: off-time codes 20/40/60/80 us, reset 01
// RULE3: off-time end: resume or repeat off-time
// RULE4: trip ignored during blanking after drive resumes
// RULE5: two-bit trip level selects four thresholds
// RULE6: strap variant: fixed trip and 40 us
// RULE7: regulation active on both outputs after reset
// RULE8: disable field turns off chopping per output
// RULE9: strap variant: strap pin disables regulation
// RULE10: three-bit slew code selects edge rate
// RULE11: slew strap: ground, floating, supply
// RULE12: dead time between opposite FETs
// RULE13: control inputs deglitched before use
// RULE14: overcurrent handled per mode or shutdown
// RULE15: controller may reverse during off-time
// RULE16: controller keeps load current moderate
// RULE17: fault pin low on any fault
// RULE18: fault pin low until core ready
// RULE19: sleep while sleep_n low
// RULE20: serial output quiet during sleep
// RULE21: controller prefers clear bit over sleep pulse
// RULE22: overcurrent modes latch, retry, report, off
// RULE23: intervals timed by clock-cycle counters
// RULE24: trip comparators synchronised per leg
module hbridge_current_chopper #(
  parameter int unsigned RETRY_CYC = `US_TO_CYC(`RETRY_US)
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // register bus
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // control pins
  input wire logic in1,
  input wire logic in2,
  input wire logic sleep_n,
  // straps
  input wire logic pin_variant_strap,
  input wire logic regulation_off_strap_n,
  input wire logic [1:0] slew_strap,
  // comparators
  input wire logic trip_a,
  input wire logic trip_b,
  input wire logic ocp_a,
  input wire logic ocp_b,
  // bridge gates, index 0 bridge_output_a, 1 bridge_output_b
  output logic [1:0] hs_gate,
  output logic [1:0] ls_gate,
  // analog settings
  output logic [1:0] trip_level_out,
  output logic [2:0] slew_rate_out,
  // fault pin, open drain
  input wire logic fault_flag_n_in,
  output logic fault_flag_n_out,
  output logic fault_flag_n_oe_n,
  // serial output permission
  output logic sdo_enable
);
  import hbridge_pkg::*;

  localparam int unsigned DEG_CYC = `NS_TO_CYC(`DEGLITCH_NS);
  localparam logic [5:0] BLANK_CYC = 6'(`NS_TO_CYC(`BLANK_NS));
  localparam logic [10:0] READY_CYC = 11'(`US_TO_CYC(`READY_US));
  localparam logic [16:0] RETRY_LD = 17'(RETRY_CYC);

  core_s c_q;
  core_s n;

  logic in1_f, in2_f, sleep_f, trip_a_f, trip_b_f, ocp_a_f, ocp_b_f;
  logic var_f, regoff_f, fault_in_f;
  logic [1:0] slew_f;
  logic aw_ok, w_ok, wr_go, awake, ocp_any, trip_hit, driving;
  logic [1:0] eff_trip, eff_off, eff_dis, eff_ocp, req;
  logic [2:0] eff_slew;
  leg_e [1:0] target;
  logic [31:0] ctrl_word, merged;
  logic [7:0] wr_addr, rd_addr;

  function automatic logic [10:0] off_cycles(input logic [1:0] sel);
    case (sel)
      2'b00: off_cycles = 11'(`US_TO_CYC(`OFF_US_0));
      2'b01: off_cycles = 11'(`US_TO_CYC(`OFF_US_1));
      2'b10: off_cycles = 11'(`US_TO_CYC(`OFF_US_2));
      default: off_cycles = 11'(`US_TO_CYC(`OFF_US_3));
    endcase
  endfunction

  // slower edges eat more of the gate ramp, so the gap grows with them
  function automatic logic [7:0] dead_cycles(input logic [2:0] sel);
    case (sel)
      3'b000: dead_cycles = 8'(`NS_TO_CYC(`DEAD_NS_0));
      3'b001: dead_cycles = 8'(`NS_TO_CYC(`DEAD_NS_1));
      3'b010: dead_cycles = 8'(`NS_TO_CYC(`DEAD_NS_2));
      3'b011: dead_cycles = 8'(`NS_TO_CYC(`DEAD_NS_3));
      3'b100: dead_cycles = 8'(`NS_TO_CYC(`DEAD_NS_4));
      3'b101: dead_cycles = 8'(`NS_TO_CYC(`DEAD_NS_5));
      3'b110: dead_cycles = 8'(`NS_TO_CYC(`DEAD_NS_6));
      default: dead_cycles = 8'(`NS_TO_CYC(`DEAD_NS_7));
    endcase
  endfunction

  // pins: two flops then a stability filter
  glitch_filter #(.CYCLES(DEG_CYC), .INIT(1'b0)) u_in1 ( // RULE13
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .pin(in1), .level(in1_f));
  glitch_filter #(.CYCLES(DEG_CYC), .INIT(1'b0)) u_in2 ( // RULE13
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .pin(in2), .level(in2_f));
  glitch_filter #(.CYCLES(DEG_CYC), .INIT(1'b0)) u_slp (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .pin(sleep_n),
    .level(sleep_f));
  glitch_filter #(.CYCLES(1), .INIT(1'b0)) u_tra ( // RULE24
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .pin(trip_a),
    .level(trip_a_f));
  glitch_filter #(.CYCLES(1), .INIT(1'b0)) u_trb ( // RULE24
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .pin(trip_b),
    .level(trip_b_f));
  glitch_filter #(.CYCLES(1), .INIT(1'b0)) u_oca (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .pin(ocp_a), .level(ocp_a_f));
  glitch_filter #(.CYCLES(1), .INIT(1'b0)) u_ocb (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .pin(ocp_b), .level(ocp_b_f));
  glitch_filter #(.CYCLES(1), .INIT(1'b0)) u_var (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .pin(pin_variant_strap),
    .level(var_f));
  glitch_filter #(.CYCLES(1), .INIT(1'b0)) u_rof (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .pin(regulation_off_strap_n),
    .level(regoff_f));
  glitch_filter #(.CYCLES(1), .INIT(1'b0)) u_sr0 (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .pin(slew_strap[0]),
    .level(slew_f[0]));
  glitch_filter #(.CYCLES(1), .INIT(1'b0)) u_sr1 (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .pin(slew_strap[1]),
    .level(slew_f[1]));
  glitch_filter #(.CYCLES(1), .INIT(1'b1)) u_fin (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .pin(fault_flag_n_in),
    .level(fault_in_f));

  always_comb begin
    n = c_q;
    n.clear_pulse = 1'b0;
    awake = sleep_f;
    ocp_any = ocp_a_f | ocp_b_f;
    req = {in1_f, in2_f};
    // strap variant pins the settings, register variant uses the word
    eff_trip = c_q.pin_variant ? `TRIP_PIN : c_q.trip_level_sel; // RULE5 RULE6
    eff_off = c_q.pin_variant ? `OFF_PIN : c_q.off_time_sel; // RULE6
    eff_dis = c_q.pin_variant ? {2{c_q.strap_reg_off}} // RULE9
                              : c_q.regulation_disable; // RULE8
    eff_slew = c_q.pin_variant ? c_q.strap_slew : c_q.slew_rate_sel;
    eff_ocp = c_q.pin_variant ? `OCP_PIN : c_q.ocp_mode; // RULE14
    ctrl_word = '0;
    ctrl_word[`CTRL_TRIP_LSB +: 2] = c_q.trip_level_sel;
    ctrl_word[`CTRL_OFF_LSB +: 2] = c_q.off_time_sel;
    ctrl_word[`CTRL_DIS_LSB +: 2] = c_q.regulation_disable;
    ctrl_word[`CTRL_SLEW_LSB +: 3] = c_q.slew_rate_sel;
    ctrl_word[`CTRL_OCP_LSB +: 2] = c_q.ocp_mode;

    // write channel: address and data in either order
    aw_ok = awvalid & c_q.awready;
    w_ok = wvalid & c_q.wready;
    if (aw_ok) begin
      n.aw_have = 1'b1;
      n.aw_addr = awaddr;
    end
    if (w_ok) begin
      n.w_have = 1'b1;
      n.w_data = wdata;
      n.w_strb = wstrb;
    end
    if (c_q.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    wr_go = n.aw_have & n.w_have & ~c_q.bvalid;
    wr_addr = {n.aw_addr[7:2], 2'b00};
    merged = ctrl_word;
    for (int b = 0; b < 4; b++) begin
      if (n.w_strb[b]) begin
        merged[b*8 +: 8] = n.w_data[b*8 +: 8];
      end
    end
    if (wr_go) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `RESP_OKAY;
      if (wr_addr == `REG_CTRL) begin
        n.trip_level_sel = merged[`CTRL_TRIP_LSB +: 2];
        n.off_time_sel = merged[`CTRL_OFF_LSB +: 2];
        n.regulation_disable = merged[`CTRL_DIS_LSB +: 2];
        n.slew_rate_sel = merged[`CTRL_SLEW_LSB +: 3];
        n.ocp_mode = merged[`CTRL_OCP_LSB +: 2];
      end else if (wr_addr == `REG_CMD) begin
        n.clear_pulse = n.w_strb[0] & n.w_data[`CMD_CLEAR_BIT];
      end else if (wr_addr == `REG_STATUS) begin
        n.bresp = `RESP_OKAY;
      end else begin
        n.bresp = `RESP_SLVERR;
      end
    end
    n.awready = ~n.aw_have & ~n.bvalid;
    n.wready = ~n.w_have & ~n.bvalid;

    // read channel
    rd_addr = {araddr[7:2], 2'b00};
    if (c_q.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && c_q.arready) begin
      n.rvalid = 1'b1;
      n.rresp = `RESP_OKAY;
      n.rdata = '0;
      if (rd_addr == `REG_CTRL) begin
        n.rdata = ctrl_word;
      end else if (rd_addr == `REG_CMD) begin
        n.rdata = '0;
      end else if (rd_addr == `REG_STATUS) begin
        n.rdata[0] = ~c_q.fault_oe_n;
        n.rdata[1] = c_q.ocp_latched;
        n.rdata[2] = c_q.ocp_shutdown;
        n.rdata[3] = (c_q.chop == CH_OFF);
        n.rdata[4] = c_q.core_ready;
        n.rdata[5] = c_q.pin_variant;
        n.rdata[6] = fault_in_f;
      end else begin
        n.rresp = `RESP_SLVERR;
      end
    end
    n.arready = ~n.rvalid;

    // wake sequence, straps caught when the core comes alive
    if (!awake) begin
      n.core_ready = 1'b0; // RULE19
      n.ready_cnt = READY_CYC - 11'h1;
    end else if (!c_q.core_ready) begin
      if (c_q.ready_cnt == 11'h0) begin
        n.core_ready = 1'b1;
        n.pin_variant = var_f;
        n.strap_reg_off = regoff_f;
        case (slew_f) // RULE11
          2'b00: n.strap_slew = `SLEW_GND;
          2'b01: n.strap_slew = `SLEW_FLOAT;
          default: n.strap_slew = `SLEW_SUPPLY;
        endcase
      end else begin
        n.ready_cnt = c_q.ready_cnt - 11'h1; // RULE23
      end
    end

    // overcurrent; a new event wins over a clear in the same cycle
    if (!awake) begin
      n.ocp_latched = 1'b0;
      n.ocp_shutdown = 1'b0;
    end else if (ocp_any && eff_ocp != 2'b11) begin // RULE22
      n.ocp_latched = 1'b1;
      n.ocp_shutdown = (eff_ocp != 2'b10); // RULE14
      n.retry_cnt = RETRY_LD - 17'h1;
    end else if (eff_ocp == 2'b01 && c_q.ocp_latched) begin
      if (c_q.retry_cnt == 17'h0) begin
        n.ocp_latched = 1'b0;
        n.ocp_shutdown = 1'b0;
      end else begin
        n.retry_cnt = c_q.retry_cnt - 17'h1;
      end
    end else if (c_q.clear_pulse) begin
      n.ocp_latched = 1'b0;
      n.ocp_shutdown = 1'b0;
    end

    // chopper
    driving = awake & c_q.core_ready & ~c_q.ocp_shutdown;
    trip_hit = (trip_a_f & ~eff_dis[0]) | (trip_b_f & ~eff_dis[1]); // RULE7
    if (!driving) begin
      n.chop = CH_DRIVE;
      n.blank_cnt = 6'h0;
    end else begin
      case (c_q.chop)
        CH_DRIVE: begin
          if (c_q.blank_cnt != 6'h0) begin
            n.blank_cnt = c_q.blank_cnt - 6'h1; // RULE4
          end else if (trip_hit && req != 2'b00) begin
            n.chop = CH_OFF; // RULE1
            n.off_cnt = off_cycles(eff_off) - 11'h1; // RULE2
            n.trip_dir = req;
          end
        end
        CH_OFF: begin
          if (c_q.off_cnt != 11'h0) begin
            n.off_cnt = c_q.off_cnt - 11'h1; // RULE23
          end else if (trip_hit) begin
            n.off_cnt = off_cycles(eff_off) - 11'h1; // RULE3
          end else begin
            n.chop = CH_DRIVE; // RULE3
            n.blank_cnt = BLANK_CYC - 6'h1;
          end
        end
        default: n.chop = CH_DRIVE;
      endcase
    end

    // leg targets from the inputs
    case (req)
      2'b01: target = '{LEG_HIGH, LEG_LOW};
      2'b10: target = '{LEG_LOW, LEG_HIGH};
      2'b11: target = '{LEG_HIGH, LEG_HIGH};
      default: target = '{LEG_HIZ, LEG_HIZ};
    endcase
    if (!driving) begin
      target = '{LEG_HIZ, LEG_HIZ}; // RULE19 RULE14
    end else if (c_q.chop == CH_OFF) begin
      // reversing speeds decay; anything else holds high-side decay
      if (!(req == ~c_q.trip_dir && (req == 2'b01 || req == 2'b10))) begin
        target = '{LEG_HIGH, LEG_HIGH}; // RULE1 RULE15
      end
    end

    // break before make on each leg
    for (int i = 0; i < 2; i++) begin
      if (target[i] != c_q.applied[i]) begin
        if (c_q.applied[i] != LEG_HIZ) begin
          n.applied[i] = LEG_HIZ; // RULE12
          n.dead_cnt[i] = dead_cycles(eff_slew) - 8'h1;
        end else if (c_q.dead_cnt[i] != 8'h0) begin
          n.dead_cnt[i] = c_q.dead_cnt[i] - 8'h1;
        end else begin
          n.applied[i] = target[i];
        end
      end else if (c_q.dead_cnt[i] != 8'h0) begin
        n.dead_cnt[i] = c_q.dead_cnt[i] - 8'h1;
      end
      n.hs_gate[i] = (n.applied[i] == LEG_HIGH);
      n.ls_gate[i] = (n.applied[i] == LEG_LOW);
    end

    n.trip_level_out = eff_trip; // RULE5
    n.slew_rate_out = eff_slew; // RULE10
    n.fault_oe_n = ~(~n.core_ready | n.ocp_latched); // RULE17 RULE18
    n.sdo_enable = awake & n.core_ready; // RULE20
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c_q <= '0;
      c_q.trip_level_sel <= `TRIP_RST;
      c_q.off_time_sel <= `OFF_RST; // RULE2
      c_q.regulation_disable <= `DIS_RST; // RULE7
      c_q.slew_rate_sel <= `SLEW_RST;
      c_q.ocp_mode <= `OCP_RST;
    end else if (ce) begin
      c_q <= n;
    end
  end

  assign awready = c_q.awready;
  assign wready = c_q.wready;
  assign bvalid = c_q.bvalid;
  assign bresp = c_q.bresp;
  assign arready = c_q.arready;
  assign rvalid = c_q.rvalid;
  assign rresp = c_q.rresp;
  assign rdata = c_q.rdata;
  assign hs_gate = c_q.hs_gate;
  assign ls_gate = c_q.ls_gate;
  assign trip_level_out = c_q.trip_level_out;
  assign slew_rate_out = c_q.slew_rate_out;
  assign fault_flag_n_out = 1'b0;
  assign fault_flag_n_oe_n = c_q.fault_oe_n;
  assign sdo_enable = c_q.sdo_enable;

  chk_off_load: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
    ce && c_q.chop == CH_DRIVE && n.chop == CH_OFF
    |=> c_q.off_cnt == off_cycles(eff_off) - 11'h1)
    else $error("off-time counter loaded with wrong length");
  chk_slow_decay: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
    ce && driving && c_q.chop == CH_OFF && req == c_q.trip_dir
    |=> ls_gate == 2'b00)
    else $error("low side on during off-time");
  chk_blank_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
    c_q.chop == CH_DRIVE && c_q.blank_cnt != 6'h0 |=> c_q.chop == CH_DRIVE)
    else $error("trip accepted during blanking");
  chk_pin_trip: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
    ce && c_q.pin_variant |=> trip_level_out == `TRIP_PIN)
    else $error("strap variant trip level not fixed");
  chk_reg_off: assert property (@(posedge aclk) disable iff (!aresetn) // RULE8
    eff_dis == 2'b11 && c_q.chop == CH_DRIVE |=> c_q.chop == CH_DRIVE)
    else $error("chopping with regulation disabled");
  chk_no_shoot: assert property (@(posedge aclk) disable iff (!aresetn) // RULE12
    $fell(hs_gate[0]) |-> !ls_gate[0] ##1 !ls_gate[0])
    else $error("low side on right after high side off");
  chk_sleep_hiz: assert property (@(posedge aclk) disable iff (!aresetn) // RULE19
    ce && !sleep_f ##1 ce |=> hs_gate == 2'b00 && ls_gate == 2'b00)
    else $error("bridge driven while asleep");
  chk_sdo_quiet: assert property (@(posedge aclk) disable iff (!aresetn) // RULE20
    ce && !sleep_f |=> !sdo_enable)
    else $error("serial output enabled in sleep");
  chk_fault_ready: assert property (@(posedge aclk) disable iff (!aresetn) // RULE18
    !c_q.core_ready |-> !fault_flag_n_oe_n)
    else $error("fault pin released before core ready");
endmodule

/* hbridge_regs.svh */
`ifndef HBRIDGE_REGS_SVH
`define HBRIDGE_REGS_SVH

// register byte offsets
`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_STATUS 8'h08

// bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// control word field positions
`define CTRL_TRIP_LSB 0
`define CTRL_OFF_LSB 2
`define CTRL_DIS_LSB 4
`define CTRL_SLEW_LSB 6
`define CTRL_OCP_LSB 9
`define CMD_CLEAR_BIT 0

// reset values of the control word
`define TRIP_RST 2'b00
`define OFF_RST 2'b01
`define DIS_RST 2'b00
`define SLEW_RST 3'b000
`define OCP_RST 2'b00

// fixed settings of the strap-configured variant
`define TRIP_PIN 2'b10
`define OFF_PIN 2'b01
`define OCP_PIN 2'b00
`define SLEW_GND 3'b000
`define SLEW_FLOAT 3'b011
`define SLEW_SUPPLY 3'b111

// timing
`define CLK_MHZ 20
`define OFF_US_0 20
`define OFF_US_1 40
`define OFF_US_2 60
`define OFF_US_3 80
`define BLANK_NS 2000
`define READY_US 50
`define DEGLITCH_NS 500
`define RETRY_US 3000
`define DEAD_NS_0 1000
`define DEAD_NS_1 1250
`define DEAD_NS_2 1500
`define DEAD_NS_3 2000
`define DEAD_NS_4 2500
`define DEAD_NS_5 3000
`define DEAD_NS_6 3500
`define DEAD_NS_7 4000
`define NS_TO_CYC(ns) ((((ns) * `CLK_MHZ) + 999) / 1000)
`define US_TO_CYC(us) ((us) * `CLK_MHZ)

`endif

/* hbridge_pkg.sv */
package hbridge_pkg;

  typedef enum logic [1:0] {
    CH_DRIVE = 2'b00,
    CH_OFF = 2'b01
  } chop_e;

  typedef enum logic [1:0] {
    LEG_HIZ = 2'b00,
    LEG_HIGH = 2'b01,
    LEG_LOW = 2'b10
  } leg_e;

  typedef struct packed {
    logic [1:0] sync;
    logic level;
    logic [3:0] cnt;
  } glitch_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_have;
    logic w_have;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [1:0] trip_level_sel;
    logic [1:0] off_time_sel;
    logic [1:0] regulation_disable;
    logic [2:0] slew_rate_sel;
    logic [1:0] ocp_mode;
    logic clear_pulse;
    logic pin_variant;
    logic strap_reg_off;
    logic [2:0] strap_slew;
    chop_e chop;
    logic [10:0] off_cnt;
    logic [5:0] blank_cnt;
    logic [1:0] trip_dir;
    leg_e [1:0] applied;
    logic [1:0][7:0] dead_cnt;
    logic [1:0] hs_gate;
    logic [1:0] ls_gate;
    logic ocp_latched;
    logic ocp_shutdown;
    logic [16:0] retry_cnt;
    logic [10:0] ready_cnt;
    logic core_ready;
    logic fault_oe_n;
    logic sdo_enable;
    logic [1:0] trip_level_out;
    logic [2:0] slew_rate_out;
  } core_s;

endpackage

/* glitch_filter.sv */
`timescale 1ns/100ps
module glitch_filter #(
  parameter int unsigned CYCLES = 1,
  parameter logic INIT = 1'b0
) (
  // clock
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // pin and clean level
  input wire logic pin,
  output logic level
);
  import hbridge_pkg::*;

  glitch_s g_q;
  glitch_s g_d;

  // sync[0] feeds only sync[1]; the filter looks at sync[1]
  always_comb begin
    g_d = g_q;
    g_d.sync = {g_q.sync[0], pin};
    if (g_q.sync[1] == g_q.level) begin
      g_d.cnt = 4'h0;
    end else if (g_q.cnt >= 4'(CYCLES - 1)) begin
      g_d.level = g_q.sync[1];
      g_d.cnt = 4'h0;
    end else begin
      g_d.cnt = g_q.cnt + 4'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      g_q <= '0;
      g_q.sync <= {2{INIT}};
      g_q.level <= INIT;
    end else if (ce) begin
      g_q <= g_d;
    end
  end

  assign level = g_q.level;
endmodule

/* load_model.sv */
`timescale 1ns/100ps
module load_model #(
  parameter int unsigned RISE = 100
) (
  // clock
  input wire logic aclk,
  // bridge gates
  input wire logic [1:0] hs_gate,
  input wire logic [1:0] ls_gate,
  // hold trip_a high, current that will not decay
  input wire logic stuck,
  // comparators
  output logic trip_a,
  output logic trip_b
);
  logic [7:0] ramp_a_q;
  logic [7:0] ramp_b_q;
  logic drive_a;
  logic drive_b;
  // current only builds while one leg sources and the other sinks
  assign drive_a = hs_gate[0] & ls_gate[1];
  assign drive_b = hs_gate[1] & ls_gate[0];
  always_ff @(posedge aclk) begin
    ramp_a_q <= drive_a ? ramp_a_q + 8'(ramp_a_q != 8'hff) : 8'h00;
    ramp_b_q <= drive_b ? ramp_b_q + 8'(ramp_b_q != 8'hff) : 8'h00;
    trip_a <= stuck | (drive_a & (ramp_a_q >= 8'(RISE)));
    trip_b <= drive_b & (ramp_b_q >= 8'(RISE));
  end
endmodule

/* hbridge_current_chopper_tb.sv */
`timescale 1ns/100ps
`include "hbridge_regs.svh"
module hbridge_current_chopper_tb;
  logic aclk = 0, aresetn = 0, ce = 1;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [3:0] wstrb = 4'hf;
  logic [2:0] awprot = 0, arprot = 0, slew_rate_out;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, sdo_enable;
  logic [1:0] bresp, rresp, r, trip_level_out, hs_gate, ls_gate;
  logic [1:0] slew_strap = 0;
  logic in1 = 0, in2 = 0, sleep_n = 1, pin_variant_strap = 0;
  logic regulation_off_strap_n = 0, stuck = 0, ocp_a = 0, ocp_b = 0;
  logic trip_a, trip_b, fault_flag_n_out, fault_flag_n_oe_n;
  int mismatches = 0, checked = 0, n;
  // pull-up on the open-drain flag
  wire pin = fault_flag_n_oe_n ? 1'b1 : fault_flag_n_out;

  hbridge_current_chopper #(.RETRY_CYC(50)) u_hbridge_current_chopper (
    .aclk, .aresetn, .ce, .awaddr, .awprot, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .in1, .in2, .sleep_n, .pin_variant_strap,
    .regulation_off_strap_n, .slew_strap, .trip_a, .trip_b, .ocp_a,
    .ocp_b, .hs_gate, .ls_gate, .trip_level_out, .slew_rate_out,
    .fault_flag_n_in(pin), .fault_flag_n_out, .fault_flag_n_oe_n,
    .sdo_enable);
  load_model u_load_model (.aclk, .hs_gate, .ls_gate, .stuck, .trip_a,
    .trip_b);

  always #25 aclk = ~aclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // both channels offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // cycles until both high sides on (want 1) or not (want 0)
  task automatic hs_wait(input logic want);
    n = 0;
    while (((hs_gate === 2'b11) !== want) && n < 5000) begin
      @(negedge aclk);
      n++;
    end
  endtask

  task automatic in_rng(input int lo, input int hi);
    check(32'(n >= lo && n <= hi), 32'd1);
  endtask

  task automatic rdy_wait(input int lim);
    n = 0;
    while (fault_flag_n_oe_n !== 1'b1 && n < lim) begin
      @(negedge aclk);
      n++;
    end
  endtask

  task automatic t_boot;
    check(fault_flag_n_oe_n, 32'd0);
    rd(`REG_CTRL);
    check(d, 32'h4);
    check(r, `RESP_OKAY);
    rd(8'h0c);
    check(r, `RESP_SLVERR);
    check(d, 32'h0);
    rdy_wait(1300);
    check(fault_flag_n_oe_n, 32'd1);
    check(sdo_enable, 32'd1);
  endtask

  task automatic t_off;
    @(posedge aclk);
    in1 <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(`REG_CTRL, 32'(c) << 2);
      hs_wait(1'b1);
      hs_wait(1'b0);
      in_rng(400 * (c + 1) - 25, 400 * (c + 1) + 2);
    end
  endtask

  // trip held past the first off-time end, so a second one follows
  task automatic t_repeat;
    wr(`REG_CTRL, 32'h0);
    hs_wait(1'b1);
    @(posedge aclk);
    stuck <= 1'b1;
    repeat (100) @(posedge aclk);
    in1 <= 1'b0;
    in2 <= 1'b1;
    repeat (60) @(negedge aclk);
    check({hs_gate, ls_gate}, 32'h9);
    @(posedge aclk);
    in1 <= 1'b1;
    in2 <= 1'b0;
    repeat (340) @(posedge aclk);
    stuck <= 1'b0;
    hs_wait(1'b0);
    n += 500;
    in_rng(775, 802);
    @(posedge aclk);
    stuck <= 1'b1;
    hs_wait(1'b1);
    in_rng(40, 120);
    @(posedge aclk);
    stuck <= 1'b0;
    hs_wait(1'b0);
  endtask

  // trip is on leg a, so only codes 00 and 10 still chop
  task automatic t_dis;
    for (int c = 0; c < 4; c++) begin
      wr(`REG_CTRL, 32'(c) << 4);
      hs_wait(1'b1);
      check(32'(n < 5000), 32'(c == 0 || c == 2));
      hs_wait(1'b0);
    end
  endtask

  task automatic t_set;
    for (int i = 0; i < 8; i++) begin
      wr(`REG_CTRL, (32'(i) << 6) | 32'(i % 4));
      repeat (3) @(negedge aclk);
      check(slew_rate_out, 32'(i));
      check(trip_level_out, 32'(i % 4));
    end
  endtask

  task automatic t_ocp;
    wr(`REG_CTRL, 32'h0);
    @(posedge aclk);
    ocp_a <= 1'b1;
    repeat (10) @(negedge aclk);
    check({hs_gate, ls_gate}, 32'h0);
    check(fault_flag_n_oe_n, 32'd0);
    @(posedge aclk);
    ocp_a <= 1'b0;
    repeat (10) @(negedge aclk);
    check({hs_gate, ls_gate}, 32'h0);
    rd(`REG_STATUS);
    check(d, 32'h17);
    wr(`REG_CMD, 32'h1);
    repeat (40) @(negedge aclk);
    check(hs_gate[0], 32'd1);
    check(fault_flag_n_oe_n, 32'd1);
    wr(`REG_CTRL, 32'h3 << 9);
    @(posedge aclk);
    ocp_a <= 1'b1;
    repeat (10) @(negedge aclk);
    check(hs_gate[0], 32'd1);
    check(fault_flag_n_oe_n, 32'd1);
    @(posedge aclk);
    ocp_a <= 1'b0;
    repeat (5) @(negedge aclk);
    wr(`REG_CTRL, 32'h1 << 9);
    @(posedge aclk);
    ocp_a <= 1'b1;
    repeat (10) @(negedge aclk);
    check({hs_gate, ls_gate}, 32'h0);
    @(posedge aclk);
    ocp_a <= 1'b0;
    repeat (80) @(negedge aclk);
    check(hs_gate[0], 32'd1);
    check(fault_flag_n_oe_n, 32'd1);
    wr(`REG_CTRL, 32'h2 << 9);
    @(posedge aclk);
    ocp_a <= 1'b1;
    repeat (10) @(negedge aclk);
    check(hs_gate[0], 32'd1);
    check(fault_flag_n_oe_n, 32'd0);
    @(posedge aclk);
    ocp_a <= 1'b0;
    repeat (5) @(negedge aclk);
    check(fault_flag_n_oe_n, 32'd0);
    wr(`REG_CMD, 32'h1);
    repeat (5) @(negedge aclk);
    check(fault_flag_n_oe_n, 32'd1);
  endtask

  task automatic t_sleep;
    @(posedge aclk);
    sleep_n <= 1'b0;
    pin_variant_strap <= 1'b1;
    regulation_off_strap_n <= 1'b1;
    slew_strap <= 2'b01;
    repeat (20) @(negedge aclk);
    check(sdo_enable, 32'd0);
    check(fault_flag_n_oe_n, 32'd0);
    check({hs_gate, ls_gate}, 32'h0);
    @(posedge aclk);
    sleep_n <= 1'b1;
    repeat (900) @(negedge aclk);
    check(fault_flag_n_oe_n, 32'd0);
    rdy_wait(400);
    check(fault_flag_n_oe_n, 32'd1);
    check(sdo_enable, 32'd1);
    repeat (2) @(negedge aclk);
    check(trip_level_out, 32'h2);
    check(slew_rate_out, 32'h3);
    hs_wait(1'b1);
    check(n, 32'd5000);
  endtask

  // a leg never conducts on both sides at once
  always @(negedge aclk) begin
    if (aresetn) check(hs_gate & ls_gate, 32'h0);
  end

  initial begin
    repeat (60000) @(posedge aclk);
    mismatches++;
    give_verdict;
  end

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(negedge aclk);
    t_boot;
    t_off;
    t_repeat;
    t_dis;
    t_set;
    t_ocp;
    t_sleep;
    give_verdict;
  end
endmodule
